//--- verif/nav_front_end_model.sv
`timescale 1ns/1ps
module nav_front_end_model (
   output logic nav_clk,
   output logic nav_data
);
   initial begin
      nav_clk  = 1'b0;
      nav_data = 1'b0;
   end

   // One bit per 48 ns; the clock stands low between bits, so it only runs within frames.
   // The bit is valid only around the edge that the chosen polarity samples, and its
   // inverse stands around the other edge, so a receiver on the wrong edge reads wrong data.
   // Afterwards the line shows the inverse value, so a released line never looks like the last bit.
   task automatic send_bit(input logic b, input logic inv);
      nav_data = b ^ inv;
      #12;
      nav_clk = 1'b1;
      #12;
      nav_data = b ^ ~inv;
      #12;
      nav_clk = 1'b0;
      #12;
      nav_data = ~b;
   endtask : send_bit
endmodule : nav_front_end_model

//--- verif/nav_sample_capture_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module nav_sample_capture_bench;
   import nav_capture_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        nav_clk, nav_data, fifo_wr_valid, spi_rx_blocked, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, fifo_wr_data, rd, w, ew, acc;
   logic [31:0] exp_q[$];
   int          num_errors, check_count, ena, sbits, slot, nsamp, cd, start, cnt, trk, pol;

   nav_sample_capture uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .nav_clk(nav_clk), .nav_data(nav_data), .fifo_wr_valid(fifo_wr_valid),
      .fifo_wr_data(fifo_wr_data), .spi_rx_blocked(spi_rx_blocked));
   nav_front_end_model u_fe (.nav_clk(nav_clk), .nav_data(nav_data));

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // The model word is queued before the bits go out, since the word appears
   // a few cycles after the last edge, well before the bit period ends when the clock is not inverted.
   task automatic send(input int n);
      logic [3:0] s;
      for (int i = 0; i < n; i++) begin
         s = 4'($urandom) >> (4 - sbits);
         if (ena == 0) ;
         else if (trk != 0 && cd == 0) cnt++;
         else begin
            acc = acc | (32'(s) << (nsamp * slot));
            nsamp++;
            if (nsamp * slot == 32) begin
               exp_q.push_back(acc);
               acc   = 32'h0;
               nsamp = 0;
            end
            if (trk != 0) begin
               cd--;
               if (cd == 0) cnt = 0;
            end
         end
         for (int b = sbits - 1; b >= 0; b--) u_fe.send_bit(s[b], 1'(pol));
      end
      repeat (12) @(posedge pclk);
   endtask : send

   task automatic cfg(input int en, input int f, input int wd, input int inv, input int tr);
      sbits = (wd != 0) ? 4 : 2;
      slot  = (f == 1) ? 4 : ((f == 2) ? sbits : 8);
      if (en == 0) begin
         acc   = 32'h0;
         nsamp = 0;
      end
      if (tr != 0 && trk == 0 && cd == 0) cnt = 0;
      if (tr == 0) cd = start;
      ena = en;
      trk = tr;
      pol = inv;
      apb(1'b1, 12'h024, 32'(en | (f << 1) | (wd << 3) | (inv << 4) | (tr << 5)), rd, err);
      repeat (2) @(posedge pclk);
      `CHK(spi_rx_blocked, 1'(en))
   endtask : cfg

   task automatic rdcnt();
      apb(1'b0, 12'h020, 32'h0, rd, err);
      `CHK(rd, 32'(cnt))
   endtask : rdcnt

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) if (fifo_wr_valid === 1'b1) begin
      ew = (exp_q.size() > 0) ? exp_q.pop_front() : ~fifo_wr_data;
      `CHK(fifo_wr_data, ew)
   end

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      #300000;
      num_errors++;
      print_verdict();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {num_errors, check_count, ena, nsamp, cd, start, cnt, trk} = '0;
      acc = 32'h0;
      void'($urandom(26));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'h020 + 12'(4 * i), 32'h0, rd, err);
         `CHK(rd, 32'h0)
      end
      apb(1'b1, 12'h024, 32'hffff_ffde, rd, err);
      apb(1'b0, 12'h024, 32'h0, rd, err);
      `CHK(rd, 32'h0000_001e)
      apb(1'b1, 12'h020, 32'h1234_5678, rd, err);
      apb(1'b0, 12'h020, 32'h0, rd, err);
      `CHK(rd, 32'h0)
      apb(1'b0, 12'h030, 32'h0, rd, err);
      `CHK({err, rd}, 33'h1_0000_0000)
      w = $urandom;
      apb(1'b1, 12'h028, w, rd, err);
      apb(1'b0, 12'h028, 32'h0, rd, err);
      `CHK(rd, w)
      $display("test registers done");
      for (int f = 0; f < 4; f++) begin
         for (int wd = 0; wd < 2; wd++) begin
            cfg(0, f, wd, f % 2, 0);
            cfg(1, f, wd, f % 2, 0);
            send(64 / slot);
            cfg(0, f, wd, f % 2, 0);
         end
      end
      cfg(0, 0, 0, 0, 0);
      send(8);
      $display("test formats done");
      // Countdown of four samples is one unpacked word, the transfer chunk size.
      apb(1'b1, 12'h028, 32'h4, rd, err);
      start = 4;
      cfg(1, 0, 0, 0, 0);
      cfg(1, 0, 0, 0, 1);
      send(12);
      rdcnt();
      cfg(1, 0, 0, 0, 0);
      send(4);
      rdcnt();
      cfg(1, 0, 0, 0, 1);
      send(6);
      rdcnt();
      cfg(1, 0, 0, 0, 0);
      apb(1'b1, 12'h028, 32'h0, rd, err);
      start = 0;
      cd    = 0;
      cfg(1, 0, 0, 0, 1);
      send(3);
      rdcnt();
      cfg(0, 0, 0, 0, 0);
      `CHK(exp_q.size(), 0)
      $display("test tracking done");
      print_verdict();
   end
endmodule : nav_sample_capture_bench

//--- verilog/nav_capture_pkg.sv
package nav_capture_pkg;

   // Register byte offsets.
   localparam logic [11:0] TRACKED_SAMPLE_COUNTER_OFS   = 12'h020;
   localparam logic [11:0] NAV_CAPTURE_CONFIG_OFS       = 12'h024;
   localparam logic [11:0] HANDOVER_COUNTDOWN_START_OFS = 12'h028;

   // Configuration field positions.
   localparam int CFG_ENABLE_BIT  = 0;
   localparam int CFG_FORMAT_LSB  = 1;
   localparam int CFG_WIDE_BIT    = 3;
   localparam int CFG_INVERT_BIT  = 4;
   localparam int CFG_TRACK_BIT   = 5;
   localparam int CFG_USED_BITS   = 6;

   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // Storage formats.
   localparam logic [1:0] FMT_UNPACKED = 2'h0;
   localparam logic [1:0] FMT_PACKED   = 2'h1;
   localparam logic [1:0] FMT_SUPER    = 2'h2;

   // Sample is sign plus one or three magnitude bits.
   localparam logic [2:0] SAMPLE_BITS_NARROW = 3'h2;
   localparam logic [2:0] SAMPLE_BITS_WIDE   = 3'h4;
   localparam logic [5:0] SLOT_UNPACKED      = 6'h08;
   localparam logic [5:0] SLOT_PACKED        = 6'h04;
   localparam logic [5:0] WORD_BITS          = 6'h20;

   typedef enum logic [2:0] {
      ST_ACQUIRE = 3'b001,
      ST_DRAIN   = 3'b010,
      ST_TRACK   = 3'b100
   } track_state_t;

endpackage : nav_capture_pkg

//--- verilog/nav_link_sampler.sv
`timescale 1ns/1ps
module nav_link_sampler (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic nav_clk,
   input  wire logic nav_data,
   input  wire logic invert,
   output logic      bit_valid_q,
   output logic      bit_data_q
);
   logic clk_s1_q;
   logic clk_s2_q;
   logic dat_s1_q;
   logic dat_s2_q;
   logic clk_prev_q;
   wire  clk_pol = clk_s2_q ^ invert;
   wire  clk_rise = clk_pol & ~clk_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_s1_q    <= 1'b0;
         clk_s2_q    <= 1'b0;
         dat_s1_q    <= 1'b0;
         dat_s2_q    <= 1'b0;
         clk_prev_q  <= 1'b0;
         bit_valid_q <= 1'b0;
         bit_data_q  <= 1'b0;
      end else begin
         clk_s1_q    <= nav_clk;
         clk_s2_q    <= clk_s1_q;
         dat_s1_q    <= nav_data;
         dat_s2_q    <= dat_s1_q;
         clk_prev_q  <= clk_pol;
         bit_valid_q <= clk_rise;
         bit_data_q  <= dat_s2_q;
      end
   end
endmodule : nav_link_sampler

//--- verilog/nav_sample_capture.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// How it works
// - When enabled, navigation samples are written to the receive FIFO port.
// - While enabled, the serial peripheral receive path is blocked from the FIFO.
// - Config bit 0 enables capture; cleared, nothing is stored.
// - Config bits 2-1 choose unpacked, packed or super packed storage.
// - Config bit 3 selects one or three magnitude bits per sample.
// - Config bit 4 inverts the navigation sample clock.
// - Config bit 5 selects acquisition or requests tracking.
// - A 32-bit register holds the countdown start value.
// - After a tracking request, storing continues until the countdown reaches zero.
// - Tracking with zero countdown counts samples instead of storing them.
// - Counted samples are discarded and never reach the FIFO.
// - The sample counter clears when counting starts.
// - Clearing the tracking request freezes the sample counter.
// - Clearing the tracking request resumes storing samples.
// - Leaving tracking reloads the countdown from its start value.
// - The read-only counter register reports the tracked sample count.
module nav_sample_capture
   import nav_capture_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        nav_clk,
   input  wire logic        nav_data,
   output logic             fifo_wr_valid,
   output logic [31:0]      fifo_wr_data,
   output logic             spi_rx_blocked
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic [5:0] slot_bits(input logic [1:0] fmt, input logic [2:0] sbits);
      case (fmt)
         FMT_PACKED: slot_bits = SLOT_PACKED;
         FMT_SUPER:  slot_bits = {3'h0, sbits};
         default:    slot_bits = SLOT_UNPACKED;
      endcase
   endfunction : slot_bits

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus.

   logic [CFG_USED_BITS-1:0] cfg_q;
   logic [31:0]              start_q;
   logic [31:0]              counter_q;
   logic [31:0]              counter_d;
   logic [31:0]              countdown_q;
   logic [31:0]              countdown_d;
   logic                     pready_q;
   logic [31:0]              prdata_q;
   logic                     pslverr_q;

   wire access    = psel & penable & ~pready_q;
   // Writes land only at the edge where the master samples pready high.
   wire done      = psel & penable & pready_q;
   wire hit_cnt   = (paddr == TRACKED_SAMPLE_COUNTER_OFS);
   wire hit_cfg   = (paddr == NAV_CAPTURE_CONFIG_OFS);
   wire hit_start = (paddr == HANDOVER_COUNTDOWN_START_OFS);
   wire mapped    = hit_cnt | hit_cfg | hit_start;
   wire wr_cfg    = done & pwrite & hit_cfg;
   wire wr_start  = done & pwrite & hit_start;
   wire [31:0] rd_mux = hit_cnt ? counter_q :
                        hit_cfg ? {{(32-CFG_USED_BITS){1'b0}}, cfg_q} :
                        hit_start ? start_q : REG_RESET;

   wire       cfg_en    = cfg_q[CFG_ENABLE_BIT];
   wire [1:0] cfg_fmt   = cfg_q[CFG_FORMAT_LSB +: 2];
   wire       cfg_wide  = cfg_q[CFG_WIDE_BIT];
   wire       cfg_inv   = cfg_q[CFG_INVERT_BIT];
   wire       track_req = cfg_q[CFG_TRACK_BIT];

   // One wait state: the answer is registered in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q     <= CFG_USED_BITS'(REG_RESET);
         start_q   <= REG_RESET;
         pready_q  <= 1'b0;
         prdata_q  <= REG_RESET;
         pslverr_q <= 1'b0;
      end else begin
         if (wr_cfg)   cfg_q   <= pwdata[CFG_USED_BITS-1:0];
         if (wr_start) start_q <= pwdata;
         pready_q  <= access;
         prdata_q  <= (access & ~pwrite) ? rd_mux : REG_RESET;
         pslverr_q <= access & ~mapped;
      end
   end

   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial link and sample assembly.

   logic bit_v;
   logic bit_d;

   nav_link_sampler u_sampler (
      .pclk        (pclk),
      .presetn     (presetn),
      .nav_clk     (nav_clk),
      .nav_data    (nav_data),
      .invert      (cfg_inv),
      .bit_valid_q (bit_v),
      .bit_data_q  (bit_d)
   );

   logic [2:0] sbit_cnt_q;
   logic [3:0] sample_sr_q;
   wire  [2:0] sbits      = cfg_wide ? SAMPLE_BITS_WIDE : SAMPLE_BITS_NARROW;
   wire        take_bit   = bit_v & cfg_en;
   wire        samp_done  = take_bit & (sbit_cnt_q == sbits - 3'h1);
   wire  [3:0] sample_now = {sample_sr_q[2:0], bit_d};
   wire  [3:0] sample_msk = cfg_wide ? sample_now : {2'h0, sample_now[1:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sbit_cnt_q  <= 3'h0;
         sample_sr_q <= 4'h0;
      end else if (!cfg_en) begin
         sbit_cnt_q  <= 3'h0;
      end else if (take_bit) begin
         sample_sr_q <= sample_now;
         sbit_cnt_q  <= samp_done ? 3'h0 : sbit_cnt_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Acquisition and tracking control.

   track_state_t st_q;
   track_state_t st_d;

   wire counting = (st_q == ST_TRACK);
   wire store    = samp_done & ~counting;

   always_comb begin
      st_d        = st_q;
      countdown_d = countdown_q;
      counter_d   = counter_q;
      case (st_q)
         ST_ACQUIRE: begin
            countdown_d = start_q;
            if (track_req) begin
               st_d = (start_q == REG_RESET) ? ST_TRACK : ST_DRAIN;
               if (start_q == REG_RESET) counter_d = REG_RESET;
            end
         end
         ST_DRAIN: begin
            if (!track_req) begin
               st_d = ST_ACQUIRE;
            end else if (samp_done) begin
               countdown_d = countdown_q - 32'h1;
               if (countdown_q == 32'h1) begin
                  st_d      = ST_TRACK;
                  counter_d = REG_RESET;
               end
            end
         end
         ST_TRACK: begin
            if (!track_req) st_d = ST_ACQUIRE;
            else if (samp_done) counter_d = counter_q + 32'h1;
         end
         default: st_d = ST_ACQUIRE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q        <= ST_ACQUIRE;
         countdown_q <= REG_RESET;
         counter_q   <= REG_RESET;
      end else begin
         st_q        <= st_d;
         countdown_q <= countdown_d;
         counter_q   <= counter_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Word packing toward the receive FIFO.

   // A format change mid-word is not realigned; software flushes the FIFO then.
   logic [31:0] word_q;
   logic [5:0]  pos_q;
   logic        wr_valid_q;
   logic [31:0] wr_data_q;
   logic        rx_blk_q;
   wire  [5:0]  slot      = slot_bits(cfg_fmt, sbits);
   wire  [31:0] word_ins  = word_q | ({28'h0, sample_msk} << pos_q);
   wire         word_full = (pos_q + slot) == WORD_BITS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q     <= REG_RESET;
         pos_q      <= 6'h0;
         wr_valid_q <= 1'b0;
         wr_data_q  <= REG_RESET;
         rx_blk_q   <= 1'b0;
      end else begin
         rx_blk_q   <= cfg_en;
         wr_valid_q <= store & word_full;
         if (store & word_full) wr_data_q <= word_ins;
         if (!cfg_en) begin
            word_q <= REG_RESET;
            pos_q  <= 6'h0;
         end else if (store) begin
            word_q <= word_full ? REG_RESET : word_ins;
            pos_q  <= word_full ? 6'h0 : pos_q + slot;
         end
      end
   end

   assign fifo_wr_valid  = wr_valid_q;
   assign fifo_wr_data   = wr_data_q;
   assign spi_rx_blocked = rx_blk_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_no_store_when_off;
      @(posedge pclk) disable iff (!presetn) !cfg_en |=> !fifo_wr_valid;
   endproperty
   a_no_store_when_off: assert property (p_no_store_when_off) else $error("store while disabled");

   property p_rx_blocked;
      @(posedge pclk) disable iff (!presetn) cfg_en |=> spi_rx_blocked;
   endproperty
   a_rx_blocked: assert property (p_rx_blocked) else $error("rx path not blocked");

   property p_track_discards;
      @(posedge pclk) disable iff (!presetn) (counting && samp_done) |=> !fifo_wr_valid;
   endproperty
   a_track_discards: assert property (p_track_discards) else $error("tracked sample stored");

   property p_track_counts;
      @(posedge pclk) disable iff (!presetn)
         (counting && track_req && samp_done) |=> counter_q == $past(counter_q) + 32'h1;
   endproperty
   a_track_counts: assert property (p_track_counts) else $error("counter not incremented");

   property p_clear_on_start;
      @(posedge pclk) disable iff (!presetn) (st_q != ST_TRACK) ##1 (st_q == ST_TRACK) |-> counter_q == 32'h0;
   endproperty
   a_clear_on_start: assert property (p_clear_on_start) else $error("counter not cleared");

   property p_freeze;
      @(posedge pclk) disable iff (!presetn) (!counting) ##1 (!counting) |-> $stable(counter_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("counter moved outside tracking");

   property p_drain_decrements;
      @(posedge pclk) disable iff (!presetn)
         (st_q == ST_DRAIN && track_req && samp_done) |=> countdown_q == $past(countdown_q) - 32'h1;
   endproperty
   a_drain_decrements: assert property (p_drain_decrements) else $error("countdown not decremented");

   property p_exit_reload;
      @(posedge pclk) disable iff (!presetn)
         (counting && !track_req) |=> (st_q == ST_ACQUIRE) ##1 countdown_q == $past(start_q);
   endproperty
   a_exit_reload: assert property (p_exit_reload) else $error("countdown not reloaded");

   property p_apb_answer;
      @(posedge pclk) disable iff (!presetn) (psel && penable && !pready) |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("bus answer late");

   property p_rx_released;
      @(posedge pclk) disable iff (!presetn) !cfg_en |=> !spi_rx_blocked;
   endproperty
   a_rx_released: assert property (p_rx_released) else $error("rx path still blocked");

   property p_ack_single;
      @(posedge pclk) disable iff (!presetn) pready |=> !pready;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("bus answer held too long");

   property p_acquire_reload;
      @(posedge pclk) disable iff (!presetn)
         (st_q == ST_ACQUIRE) |=> countdown_q == $past(start_q);
   endproperty
   a_acquire_reload: assert property (p_acquire_reload) else $error("countdown not reloaded");

   c_enter_track: cover property (@(posedge pclk) disable iff (!presetn) st_q == ST_DRAIN ##1 st_q == ST_TRACK);
   c_word_out:    cover property (@(posedge pclk) disable iff (!presetn) fifo_wr_valid);
   c_leave_track: cover property (@(posedge pclk) disable iff (!presetn) st_q == ST_TRACK ##1 st_q == ST_ACQUIRE);
   c_direct_track: cover property (@(posedge pclk) disable iff (!presetn) st_q == ST_ACQUIRE ##1 st_q == ST_TRACK);

endmodule : nav_sample_capture
